// ===== gpio_dec_pkg.sv
// Constants shared by the general purpose pin decoder and its comparator.
`default_nettype none
package gpio_dec_pkg;

  // Configuration access.
  localparam logic [7:0]  CFG_UNLOCK_VALUE = 8'h89;
  localparam logic [7:0]  IDX_PIN0_ADDR_LO = 8'h10;
  localparam logic [7:0]  IDX_PIN0_ADDR_HI = 8'h11;
  localparam logic [7:0]  IDX_PIN1_ADDR_LO = 8'h12;
  localparam logic [7:0]  IDX_PIN1_ADDR_HI = 8'h13;
  localparam logic [7:0]  IDX_PIN0_FUNC    = 8'h14;
  localparam int          NUM_CFG_REGS     = 5;
  localparam logic [7:0]  CFG_REG_RESET    = 8'h00;
  localparam logic [7:0]  INDEX_RESET      = 8'h00;
  localparam logic [7:0]  HIGH_REG_MASK    = 8'hC7;
  localparam logic [7:0]  FULL_REG_MASK    = 8'hFF;

  // Default I/O port addresses of the configuration ports.
  localparam logic [10:0] DEF_UNLOCK_PORT  = 11'h250;
  localparam logic [10:0] DEF_INDEX_PORT   = 11'h251;
  localparam logic [10:0] DEF_DATA_PORT    = 11'h252;

  // Field positions in the high address register.
  localparam int          SIZE_MSB         = 7;
  localparam int          SIZE_LSB         = 6;
  localparam int          ADDR_HI_MSB      = 2;

  // Field positions in the pin 0 function control register.
  localparam int          FUNC_MSB         = 7;
  localparam int          FUNC_LSB         = 5;
  localparam int          POLARITY_BIT     = 4;
  localparam int          SEL_READ_BIT     = 3;
  localparam int          SEL_WRITE_BIT    = 2;
  localparam int          WR_INV_BIT       = 1;
  localparam int          RD_INV_BIT       = 0;

  // Pin 0 functions; any code with the top bit set is a chip select.
  localparam logic [2:0]  FUNC_OFF         = 3'b000;
  localparam logic [2:0]  FUNC_OUT         = 3'b001;
  localparam logic [2:0]  FUNC_IN          = 3'b010;
  localparam logic [2:0]  FUNC_BIDIR       = 3'b011;
  localparam int          FUNC_CS_BIT      = 2;

  // Decode sizes.
  localparam logic [1:0]  SIZE_1_BYTE      = 2'b00;
  localparam logic [1:0]  SIZE_2_BYTES     = 2'b01;
  localparam logic [1:0]  SIZE_4_BYTES     = 2'b10;
  localparam logic [1:0]  SIZE_8_BYTES     = 2'b11;

  // Synchroniser word: {aen, ior_n, iow_n, sa[10:0], sd[7:0], pin}.
  localparam int          SYNC_W           = 23;
  localparam logic [22:0] SYNC_IDLE        = 23'h700000;

  typedef enum logic [0:0] {
    CFG_LOCKED   = 1'b0,
    CFG_UNLOCKED = 1'b1
  } cfg_state_t;

endpackage : gpio_dec_pkg
`default_nettype wire

// ===== addr_match_if.sv
// Signals between the decoder and one address window comparator.
`timescale 1ns/10ps
`default_nettype none
interface addr_match_if;
  logic [10:0] base;
  logic [10:0] addr;
  logic [1:0]  size;
  logic        hit;

  modport comparator (input base, input addr, input size, output hit);
  modport user       (output base, output addr, output size, input hit);
endinterface : addr_match_if
`default_nettype wire

// ===== addr_window_match.sv
// Address window comparator of 1, 2, 4 or 8 bytes.
`timescale 1ns/10ps
`default_nettype none
module addr_window_match
  import gpio_dec_pkg::*;
(
  addr_match_if.comparator bus            // Window base, size and hit
);

  logic [10:0] care;

  always_comb begin
    unique case (bus.size)
      SIZE_1_BYTE:  care = 11'h7FF; // R03
      SIZE_2_BYTES: care = 11'h7FE; // R05
      SIZE_4_BYTES: care = 11'h7FC; // R05
      SIZE_8_BYTES: care = 11'h7F8; // R03
    endcase
  end

  assign bus.hit = ((bus.addr ^ bus.base) & care) == 11'h000;

endmodule : addr_window_match
`default_nettype wire

// ===== isa_gpio_pin_decoder.sv
// ISA I/O decoder for two general purpose pins with indexed configuration.
//
// Overview of operation
// R01 - Software unlocks with 0x89, writes an index, then uses the data port.
// R02 - Pin 0 address is 11 bits: low byte at 0x10, top three at 0x11.
// R03 - Pin 0 size code in 0x11 bits 7..6 ignores 0 to 3 address bits.
// R04 - Pin 1 address is 11 bits: low byte at 0x12, top three at 0x13.
// R05 - Pin 1 size code in 0x13 bits 7..6, coded as for pin 0.
// R06 - Bits 5..3 of 0x11 and 0x13 are reserved and read as zero.
// R07 - Function 000 tri-states pin 0; top bit set makes a chip select.
// R08 - Function 001 drives latched SD0 onto pin 0 after a matching write.
// R09 - Function 010 returns pin 0 level on SD0 during matching reads.
// R10 - Function 011 writes SD0 to the pin and reads the pin back.
// R11 - Chip select asserts on AEN low, address match and chosen strobes.
// R12 - Bit 4 of 0x14 picks chip select level: 0 low, 1 high.
// R13 - Bits 3..2 of 0x14 qualify select: none, write, read, either.
// R14 - Bit 0 inverts the read path, bit 1 the write path, independently.
// R15 - No match, AEN high or no read function leaves SD undriven.
// R16 - Written pin value latches at write strobe end, holds until next.
`timescale 1ns/10ps
`default_nettype none
module isa_gpio_pin_decoder
  import gpio_dec_pkg::*;
#(
  parameter logic [10:0] UNLOCK_PORT = DEF_UNLOCK_PORT,
  parameter logic [10:0] INDEX_PORT  = DEF_INDEX_PORT,
  parameter logic [10:0] DATA_PORT   = DEF_DATA_PORT
) (
  input  wire logic        clk_in,         // 250 MHz clock
  input  wire logic        rst_in,         // Synchronous reset, active high
  input  wire logic        aen_in,         // ISA address enable
  input  wire logic        ior_n_in,       // ISA I/O read strobe, low active
  input  wire logic        iow_n_in,       // ISA I/O write strobe, low active
  input  wire logic [10:0] sa_in,          // ISA address
  input  wire logic [7:0]  sd_in,          // ISA data, level on the wire
  input  wire logic        gp_pin0_in,     // Pin 0 level on the wire
  output logic      [7:0]  sd_out,         // ISA data driven value
  output logic      [7:0]  sd_oe_out,      // ISA data drive enable per bit
  output logic             gp_pin0_out,    // Pin 0 driven value
  output logic             gp_pin0_oe_out, // Pin 0 drive enable
  output logic             pin1_hit_out    // Pin 1 window hit with AEN low
);

  // Every bus and pin input crosses in through two flip-flops.
  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync_meta <= SYNC_IDLE;
      sync_q    <= SYNC_IDLE;
    end else begin
      sync_meta <= {aen_in, ior_n_in, iow_n_in, sa_in, sd_in, gp_pin0_in};
      sync_q    <= sync_meta;
    end
  end

  logic        aen_s;
  logic        ior_s;
  logic        iow_s;
  logic [10:0] sa_s;
  logic [7:0]  sd_s;
  logic        pin_s;

  assign aen_s = sync_q[22];
  assign ior_s = sync_q[21];
  assign iow_s = sync_q[20];
  assign sa_s  = sync_q[19:9];
  assign sd_s  = sync_q[8:1];
  assign pin_s = sync_q[0];

  // Writes take effect at the end of the strobe, when the data is settled.
  logic iow_prev;
  logic write_end;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      iow_prev <= 1'b1;
    end else begin
      iow_prev <= iow_s;
    end
  end

  assign write_end = iow_s & ~iow_prev & ~aen_s;

  // Configuration access state.
  cfg_state_t  cfg_state;
  logic [7:0]  cfg_index;
  logic [7:0]  cfg_reg [NUM_CFG_REGS];
  logic        unlocked;

  assign unlocked = (cfg_state == CFG_UNLOCKED);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cfg_state <= CFG_LOCKED;
    end else if (write_end && sa_s == UNLOCK_PORT) begin
      // Any other value written here locks the registers again.
      unique case (sd_s == CFG_UNLOCK_VALUE)
        1'b1: cfg_state <= CFG_UNLOCKED; // R01
        1'b0: cfg_state <= CFG_LOCKED;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cfg_index <= INDEX_RESET;
    end else if (write_end && unlocked && sa_s == INDEX_PORT) begin
      cfg_index <= sd_s; // R01
    end
  end

  for (genvar r = 0; r < NUM_CFG_REGS; r++) begin : g_cfg
    localparam logic [7:0] WMASK = (r == 1 || r == 3) ? HIGH_REG_MASK
                                                      : FULL_REG_MASK;
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        cfg_reg[r] <= CFG_REG_RESET;
      end else if (write_end && unlocked && sa_s == DATA_PORT &&
                   cfg_index == IDX_PIN0_ADDR_LO + 8'(r)) begin
        cfg_reg[r] <= sd_s & WMASK; // R02 R04 R06
      end
    end
  end

  logic [7:0] idx_off;
  logic [7:0] data_val;

  assign idx_off = cfg_index - IDX_PIN0_ADDR_LO;

  always_comb begin
    data_val = 8'h00;
    if (cfg_index >= IDX_PIN0_ADDR_LO && cfg_index <= IDX_PIN0_FUNC) begin
      data_val = cfg_reg[idx_off[2:0]];
    end
  end

  // Address windows of both pins.
  addr_match_if match_bus [2] ();

  for (genvar p = 0; p < 2; p++) begin : g_win
    assign match_bus[p].base = {cfg_reg[2*p+1][ADDR_HI_MSB:0],
                                cfg_reg[2*p]}; // R02 R04
    assign match_bus[p].size = cfg_reg[2*p+1][SIZE_MSB:SIZE_LSB]; // R03 R05
    assign match_bus[p].addr = sa_s;
    addr_window_match u_match (
      .bus (match_bus[p].comparator)
    );
  end

  // Pin 0 function fields.
  logic [2:0] func_sel;
  logic       sel_polarity;
  logic       sel_on_read;
  logic       sel_on_write;
  logic       wr_invert;
  logic       rd_invert;

  assign func_sel     = cfg_reg[4][FUNC_MSB:FUNC_LSB];
  assign sel_polarity = cfg_reg[4][POLARITY_BIT];
  assign sel_on_read  = cfg_reg[4][SEL_READ_BIT];
  assign sel_on_write = cfg_reg[4][SEL_WRITE_BIT];
  assign wr_invert    = cfg_reg[4][WR_INV_BIT];
  assign rd_invert    = cfg_reg[4][RD_INV_BIT];

  logic pin0_hit;
  logic pin0_latch;
  logic next_pin0_latch;
  logic pin0_write;
  logic select_qual;
  logic select_on;
  logic gpio_read;
  logic cfg_read;
  logic next_pin0_out;
  logic next_pin0_oe;
  logic [7:0] next_sd;
  logic [7:0] next_sd_oe;

  assign pin0_hit   = match_bus[0].hit & ~aen_s;
  assign pin0_write = write_end & match_bus[0].hit &
                      (func_sel == FUNC_OUT || func_sel == FUNC_BIDIR);
  // The output function takes SD0 on writes, as the bidirectional one does.
  assign next_pin0_latch = pin0_write ? (sd_s[0] ^ wr_invert) // R08 R14
                                      : pin0_latch;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin0_latch <= 1'b0;
    end else begin
      pin0_latch <= next_pin0_latch; // R16
    end
  end

  always_comb begin
    unique case ({sel_on_read, sel_on_write})
      2'b00: select_qual = 1'b1;              // R13
      2'b01: select_qual = ~iow_s;            // R13
      2'b10: select_qual = ~ior_s;            // R13
      2'b11: select_qual = ~iow_s | ~ior_s;   // R13
    endcase
  end

  assign select_on = pin0_hit & select_qual; // R11

  always_comb begin
    next_pin0_oe  = 1'b0;
    next_pin0_out = 1'b0;
    if (func_sel[FUNC_CS_BIT]) begin
      next_pin0_oe  = 1'b1; // R07
      next_pin0_out = select_on ? sel_polarity : ~sel_polarity; // R12
    end else if (func_sel == FUNC_OUT || func_sel == FUNC_BIDIR) begin
      next_pin0_oe  = 1'b1; // R10
      next_pin0_out = next_pin0_latch;
    end
  end

  assign gpio_read = ~ior_s & pin0_hit &
                     (func_sel == FUNC_IN || func_sel == FUNC_BIDIR); // R09
  assign cfg_read  = ~ior_s & ~aen_s & unlocked &
                     (sa_s == DATA_PORT || sa_s == INDEX_PORT);

  // A configuration read wins if a pin window overlaps the config ports.
  always_comb begin
    next_sd    = 8'h00;
    next_sd_oe = 8'h00; // R15
    if (cfg_read) begin
      next_sd_oe = 8'hFF;
      next_sd    = (sa_s == INDEX_PORT) ? cfg_index : data_val;
    end else if (gpio_read) begin
      next_sd_oe = 8'h01;
      next_sd    = {7'h00, pin_s ^ rd_invert}; // R10 R14
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sd_out         <= 8'h00;
      sd_oe_out      <= 8'h00;
      gp_pin0_out    <= 1'b0;
      gp_pin0_oe_out <= 1'b0;
      pin1_hit_out   <= 1'b0;
    end else begin
      sd_out         <= next_sd;
      sd_oe_out      <= next_sd_oe;
      gp_pin0_out    <= next_pin0_out;
      gp_pin0_oe_out <= next_pin0_oe;
      pin1_hit_out   <= match_bus[1].hit & ~aen_s;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_unlock;
    write_end && sa_s == UNLOCK_PORT && sd_s == CFG_UNLOCK_VALUE
      |=> unlocked;
  endproperty
  a_unlock: assert property (p_unlock) // R01
    else $error("unlock value did not open configuration");

  property p_addr_low_write;
    write_end && unlocked && sa_s == DATA_PORT &&
      cfg_index == IDX_PIN0_ADDR_LO |=> cfg_reg[0] == $past(sd_s);
  endproperty
  a_addr_low_write: assert property (p_addr_low_write) // R02
    else $error("pin 0 low address not stored");

  property p_reserved_zero;
    cfg_reg[1][5:3] == 3'h0 && cfg_reg[3][5:3] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // R06
    else $error("reserved high address bits are not zero");

  property p_eight_byte_window;
    match_bus[0].size == SIZE_8_BYTES &&
      sa_s[10:3] == match_bus[0].base[10:3] |-> match_bus[0].hit;
  endproperty
  a_eight_byte_window: assert property (p_eight_byte_window) // R03
    else $error("eight byte window missed an address");

  property p_off_tristate;
    func_sel == FUNC_OFF |=> !gp_pin0_oe_out;
  endproperty
  a_off_tristate: assert property (p_off_tristate) // R07
    else $error("pin 0 driven while inactive");

  property p_select_level;
    func_sel[FUNC_CS_BIT] && pin0_hit && !sel_on_read && !sel_on_write
      |=> gp_pin0_oe_out && gp_pin0_out == $past(sel_polarity);
  endproperty
  a_select_level: assert property (p_select_level) // R11 R12
    else $error("chip select not at its active level");

  property p_select_needs_write;
    func_sel[FUNC_CS_BIT] && !sel_on_read && sel_on_write && iow_s
      |=> gp_pin0_out == !$past(sel_polarity);
  endproperty
  a_select_needs_write: assert property (p_select_needs_write) // R13
    else $error("write qualified select active without strobe");

  property p_read_path;
    func_sel == FUNC_IN && pin0_hit && !ior_s && !cfg_read
      |=> sd_oe_out == 8'h01 && sd_out[0] == $past(pin_s ^ rd_invert);
  endproperty
  a_read_path: assert property (p_read_path) // R09 R14
    else $error("pin level not returned on SD0");

  property p_no_drive;
    aen_s |=> sd_oe_out == 8'h00;
  endproperty
  a_no_drive: assert property (p_no_drive) // R15
    else $error("data bus driven with AEN high");

  property p_write_latch;
    pin0_write ##1 !pin0_write [*2]
      |-> gp_pin0_out == $past(sd_s[0] ^ wr_invert, 2);
  endproperty
  a_write_latch: assert property (p_write_latch) // R16 R10
    else $error("written pin value not latched and held");

  c_unlock:      cover property (write_end && sa_s == UNLOCK_PORT);
  c_select_on:   cover property (func_sel[FUNC_CS_BIT] && select_on);
  c_gpio_read:   cover property (gpio_read && !cfg_read);
  c_pin0_write:  cover property (pin0_write);

endmodule : isa_gpio_pin_decoder
`default_nettype wire

// ===== isa_host_model.sv
// Behavioural ISA host issuing I/O read and write cycles.
`timescale 1ns/10ps
`default_nettype none
module isa_host_model (
  input  wire logic        clk_in,    // Bus clock
  input  wire logic [7:0]  sd_in,     // Level on the data wire
  output logic             aen_out,   // Address enable
  output logic             ior_n_out, // Read strobe
  output logic             iow_n_out, // Write strobe
  output logic      [10:0] sa_out,    // Address
  output logic      [7:0]  sd_out,    // Data offered by the host
  output logic             mid_out    // High through the strobe phase
);
  initial begin
    aen_out = 1'b1;
    ior_n_out = 1'b1;
    iow_n_out = 1'b1;
    sa_out = 11'h000;
    sd_out = 8'h00;
    mid_out = 1'b0;
  end

  // With neither strobe the cycle only presents the address.
  // Each cycle ends by inverting the byte the host offers on a released data wire.
  task automatic cycle(input logic [10:0] a, input logic rd,
                       input logic wr, input logic [7:0] d,
                       output logic [7:0] q);
    @(negedge clk_in);
    aen_out = 1'b0;
    sa_out = a;
    if (wr) sd_out = d;
    ior_n_out = ~rd;
    iow_n_out = ~wr;
    mid_out = 1'b1;
    repeat (5) @(posedge clk_in);
    // Sample off the edge, so the registered answer has settled.
    @(negedge clk_in);
    q = sd_in;
    ior_n_out = 1'b1;
    iow_n_out = 1'b1;
    mid_out = 1'b0;
    // Address and data stay put while the write end crosses the sync.
    repeat (4) @(negedge clk_in);
    aen_out = 1'b1;
    sd_out = ~sd_out;
    repeat (3) @(negedge clk_in);
  endtask : cycle
endmodule : isa_host_model
`default_nettype wire

// ===== isa_gpio_pin_decoder_tb_top.sv
// Self-checking bench for the general purpose pin decoder.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module isa_gpio_pin_decoder_tb_top
  import gpio_dec_pkg::*;
;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        pin_drv = 1'b0;
  logic        aen, ior_n, iow_n, mid, gp_o, gp_oe, p1, c_gp, c_p1;
  logic [10:0] sa;
  logic [7:0]  h_sd, sd_o, sd_oe, c_sd, c_oe, q;
  int          n_fail = 0;
  int          checks = 0;
  wire  [7:0]  sd_w = (sd_oe & sd_o) | (~sd_oe & h_sd);
  wire         gp_w = gp_oe ? gp_o : pin_drv;

  always #2 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    if (mid) begin
      c_sd <= sd_w;
      c_oe <= sd_oe;
      c_gp <= gp_o;
      c_p1 <= p1;
    end
  end

  isa_host_model h (.clk_in(clk_in), .sd_in(sd_w), .aen_out(aen),
    .ior_n_out(ior_n), .iow_n_out(iow_n), .sa_out(sa), .sd_out(h_sd),
    .mid_out(mid));
  isa_gpio_pin_decoder i_dut (.clk_in(clk_in), .rst_in(rst_in),
    .aen_in(aen), .ior_n_in(ior_n), .iow_n_in(iow_n), .sa_in(sa),
    .sd_in(sd_w), .gp_pin0_in(gp_w), .sd_out(sd_o), .sd_oe_out(sd_oe),
    .gp_pin0_out(gp_o), .gp_pin0_oe_out(gp_oe), .pin1_hit_out(p1));

  // Index first, then data, once the ports are unlocked.
  task automatic cfg(input logic [7:0] idx, input logic [7:0] v);
    h.cycle(DEF_INDEX_PORT, 1'b0, 1'b1, idx, q);
    h.cycle(DEF_DATA_PORT, 1'b0, 1'b1, v, q);
  endtask : cfg

  task automatic cfg_chk(input logic [7:0] idx, input logic [7:0] e);
    h.cycle(DEF_INDEX_PORT, 1'b0, 1'b1, idx, q);
    h.cycle(DEF_DATA_PORT, 1'b1, 1'b0, 8'h00, q);
    `CHK(c_oe, 8'hFF)
    `CHK(c_sd, e)
    `CHK(q, e)
  endtask : cfg_chk

  task automatic t_regs;
    logic [7:0] ix;
    h.cycle(DEF_DATA_PORT, 1'b1, 1'b0, 8'h00, q);
    `CHK(c_oe, 8'h00)
    h.cycle(DEF_UNLOCK_PORT, 1'b0, 1'b1, CFG_UNLOCK_VALUE, q);
    for (int i = 0; i < NUM_CFG_REGS; i++) begin
      ix = IDX_PIN0_ADDR_LO + 8'(i);
      cfg_chk(ix, CFG_REG_RESET);
      cfg(ix, 8'hFF);
      cfg_chk(ix, (i == 1 || i == 3) ? HIGH_REG_MASK
                                     : FULL_REG_MASK);
    end
    cfg_chk(8'h15, 8'h00);
    h.cycle(DEF_INDEX_PORT, 1'b1, 1'b0, 8'h00, q);
    `CHK(q, 8'h15)
    // Any other value on the unlock port closes the ports again.
    h.cycle(DEF_UNLOCK_PORT, 1'b0, 1'b1, 8'h00, q);
    h.cycle(DEF_DATA_PORT, 1'b1, 1'b0, 8'h00, q);
    `CHK(c_oe, 8'h00)
    h.cycle(DEF_UNLOCK_PORT, 1'b0, 1'b1, CFG_UNLOCK_VALUE, q);
    $display("t_regs done");
  endtask : t_regs

  // Probe one address bit at a time against each window size.
  task automatic t_size;
    logic [10:0] a;
    logic        e;
    cfg(IDX_PIN0_ADDR_LO, 8'h00);
    cfg(IDX_PIN1_ADDR_LO, 8'h00);
    cfg(IDX_PIN0_FUNC, 8'h90);
    for (int s = 0; s < 4; s++) begin
      cfg(IDX_PIN0_ADDR_HI, {2'(s), 6'h03});
      cfg(IDX_PIN1_ADDR_HI, {2'(s), 6'h03});
      for (int k = 0; k < 5; k++) begin
        a = 11'h300 | ((11'h001 << k) & 11'h00F);
        e = (k == 4) || (k < s);
        h.cycle(a, 1'b0, 1'b0, 8'h00, q);
        `CHK(c_gp, e)
        `CHK(c_p1, e)
      end
    end
    $display("t_size done");
  endtask : t_size

  task automatic t_cs;
    logic pol;
    logic act;
    cfg(IDX_PIN0_ADDR_HI, 8'h03);
    for (int f = 0; f < 8; f++) begin
      pol = f[2];
      cfg(IDX_PIN0_FUNC, {1'b1, 2'(f), pol, 2'(f), 2'b00});
      for (int c = 0; c < 3; c++) begin
        act = (f[1:0] == 2'b00) || (f[1] && c == 1) || (f[0] && c == 2);
        h.cycle(11'h300, c == 1, c == 2, 8'h00, q);
        `CHK(c_gp, act ? pol : ~pol)
        `CHK(c_oe, 8'h00)
      end
      h.cycle(11'h301, 1'b1, 1'b0, 8'h00, q);
      `CHK(c_gp, ~pol)
      `CHK(gp_oe, 1'b1)
    end
    $display("t_cs done");
  endtask : t_cs

  task automatic t_data;
    logic [1:0] v;
    for (int i = 0; i < 4; i++) begin
      v = 2'(i);
      cfg(IDX_PIN0_FUNC, {FUNC_OUT, 3'b000, v});
      h.cycle(11'h300, 1'b0, 1'b1, 8'h01, q);
      `CHK(gp_o, ~v[1])
      h.cycle(11'h300, 1'b0, 1'b1, 8'h00, q);
      `CHK(c_gp, ~v[1])
      `CHK(gp_o, v[1])
      h.cycle(11'h301, 1'b0, 1'b1, 8'h01, q);
      `CHK(gp_o, v[1])
      `CHK(gp_oe, 1'b1)
      cfg(IDX_PIN0_FUNC, {FUNC_IN, 3'b000, v});
      pin_drv = v[1];
      h.cycle(11'h300, 1'b1, 1'b0, 8'h00, q);
      `CHK(c_oe, 8'h01)
      `CHK(q[0], v[1] ^ v[0])
      `CHK(gp_oe, 1'b0)
      cfg(IDX_PIN0_FUNC, {FUNC_BIDIR, 3'b000, v});
      h.cycle(11'h300, 1'b0, 1'b1, 8'h00, q);
      `CHK(gp_o, v[1])
      h.cycle(11'h300, 1'b1, 1'b0, 8'h00, q);
      `CHK(q[0], v[1] ^ v[0])
      h.cycle(11'h308, 1'b1, 1'b0, 8'h00, q);
      `CHK(c_oe, 8'h00)
      cfg(IDX_PIN0_FUNC, {FUNC_OFF, 3'b000, v});
      `CHK(gp_oe, 1'b0)
    end
    $display("t_data done");
  endtask : t_data

  task automatic print_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    t_regs;
    t_size;
    t_cs;
    t_data;
    print_verdict;
  end

  // The whole run needs about 10 us; ten times that means a hang.
  initial begin
    #100000;
    n_fail++;
    print_verdict;
  end
endmodule : isa_gpio_pin_decoder_tb_top
`default_nettype wire
